// ===== bench/spv_port_chk.sv
// Checker of the serial program/verify port outputs
`timescale 1ns/1ps
`default_nettype none
module spv_port_chk (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Programmer pins
    input wire logic HIGH_VOLTAGE_SELECT_PIN,
    input wire logic PROG_SERIAL_CLOCK,
    input wire logic PROG_SERIAL_DATA_IN,
    input wire logic PROG_SERIAL_DATA_OUT,
    input wire logic PROG_SERIAL_DATA_OE,
    // Device status
    input wire logic CORE_RESET_N,
    input wire logic PROG_MODE,
    input wire logic ERASE_BUSY,
    input wire logic PROGRAM_ACTIVE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);
    // Cycles of the running sweep; counted, since the sweep outlasts any delay range
    logic [10:0] erase_len_r;
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            erase_len_r <= 11'h000;
        else if (ERASE_BUSY)
            erase_len_r <= erase_len_r + 11'h001;
        else
            erase_len_r <= 11'h000;
    end
    // Erase sweep holds for a while once started
    sequence erase_hold_s;
        ERASE_BUSY [*8];
    endsequence
    // Synchroniser latency is three cycles, so each bound leaves a margin
    AST_CORE_HELD: assert property (PROG_MODE |-> !CORE_RESET_N)
        else $error("core not held in mode");
    AST_CORE_FREE: assert property (!PROG_MODE |-> CORE_RESET_N)
        else $error("core held outside mode");
    AST_CORE_PIN: assert property (HIGH_VOLTAGE_SELECT_PIN [*6] |-> !CORE_RESET_N)
        else $error("core free while entry voltage held");
    AST_ENTRY: assert property (HIGH_VOLTAGE_SELECT_PIN [*6] |-> PROG_MODE)
        else $error("mode not entered");
    AST_EXIT: assert property (!HIGH_VOLTAGE_SELECT_PIN [*5] |-> !PROG_MODE && !PROG_SERIAL_DATA_OE)
        else $error("mode not left");
    AST_OE_RISE: assert property ($rose(PROG_SERIAL_DATA_OE) |-> PROG_SERIAL_CLOCK && PROG_MODE)
        else $error("drive starts off a rising clock");
    AST_OE_FALL: assert property ($fell(PROG_SERIAL_DATA_OE) && PROG_MODE |-> PROG_SERIAL_CLOCK)
        else $error("drive ends off a rising clock");
    AST_BIT_SHIFT: assert property (PROG_SERIAL_DATA_OE && $past(PROG_SERIAL_DATA_OE)
        && $changed(PROG_SERIAL_DATA_OUT) |-> PROG_SERIAL_CLOCK)
        else $error("read bit changed while clock low");
    AST_PROG_START: assert property ($rose(PROGRAM_ACTIVE) |-> !PROG_SERIAL_CLOCK && PROG_MODE)
        else $error("programming start off a command");
    AST_ERASE_START: assert property ($rose(ERASE_BUSY) |-> !PROG_SERIAL_CLOCK)
        else $error("erase start off a falling clock");
    AST_ERASE_LEN: assert property ($rose(ERASE_BUSY) |-> erase_hold_s)
        else $error("erase sweep too short");
    AST_ERASE_END: assert property ($fell(ERASE_BUSY) |-> erase_len_r == 11'h400)
        else $error("erase sweep length wrong");
    AST_ERASE_BOUND: assert property (ERASE_BUSY |-> erase_len_r < 11'h400)
        else $error("erase sweep overran");
endmodule : spv_port_chk
bind serial_program_verify_port spv_port_chk i_spv_port_chk (.CLK_SYS, .RESETN, .HIGH_VOLTAGE_SELECT_PIN,
    .PROG_SERIAL_CLOCK, .PROG_SERIAL_DATA_IN, .PROG_SERIAL_DATA_OUT, .PROG_SERIAL_DATA_OE, .CORE_RESET_N,
    .PROG_MODE, .ERASE_BUSY, .PROGRAM_ACTIVE);
`default_nettype wire

// ===== bench/spv_programmer.sv
// Behavioural model of the external programmer
`timescale 1ns/1ps
`default_nettype none
module spv_programmer (
    // Pacing clock
    input wire logic clk,
    // Device data driver
    input wire logic oe,
    input wire logic dout,
    // Programmer pins
    output logic sclk,
    output logic hv,
    output wire logic din
);
    logic val = 1'b0;
    logic [15:0] rd_bits;
    logic [15:0] oe_bits;
    // Device wins the line while it drives
    assign din = oe ? dout : val;
    initial
    begin
        sclk = 1'b0;
        hv = 1'b0;
    end
    // Half a 400 ns serial period
    task automatic half;
        repeat (4) @(negedge clk);
    endtask : half
    // One clock; a released line flips so a stale level never passes
    task automatic pulse(input logic b, input logic rel, input int i);
        sclk = 1'b1;
        val = rel ? ~val : b;
        half();
        rd_bits[i] = din;
        oe_bits[i] = oe;
        sclk = 1'b0;
        half();
    endtask : pulse
    // Six clocks LSb first, then the gap
    task automatic cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++)
            pulse(c[i], 1'b0, i);
        val = 1'b0;
        repeat (2) half();
    endtask : cmd
    // Start, 14 bits LSb first, stop
    task automatic load(input logic [13:0] w);
        logic [15:0] f;
        f = {1'b0, w, 1'b0};
        for (int i = 0; i < 16; i++)
            pulse(f[i], 1'b0, i);
        repeat (2) half();
    endtask : load
    task automatic read;
        for (int i = 0; i < 16; i++)
            pulse(1'b0, 1'b1, i);
        val = 1'b0;
        repeat (2) half();
    endtask : read
    // Clock and data low before high voltage
    task automatic enter;
        sclk = 1'b0;
        val = 1'b0;
        repeat (2) half();
        hv = 1'b1;
        repeat (2) half();
    endtask : enter
    task automatic leave;
        hv = 1'b0;
        repeat (2) half();
    endtask : leave
endmodule : spv_programmer
`default_nettype wire

// ===== bench/test_serial_program_verify_port.sv
// Self-checking bench of the serial program/verify port
`timescale 1ns/1ps
`default_nettype none
module test_serial_program_verify_port;
    logic CLK_SYS = 1'b0;
    logic RESETN = 1'b0;
    wire logic sclk, hv, din, dout, oe, core_n, mode, ebusy, pact;
    int bad_count = 0;
    int checked = 0;
    int wait_n;
    logic [15:0] seed = 16'h8602;
    logic [11:0] w;
    // 20 MHz system clock
    initial
    begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    // Far side and device
    spv_programmer i_spv_programmer (.clk(CLK_SYS), .oe(oe), .dout(dout), .sclk(sclk), .hv(hv), .din(din));
    serial_program_verify_port i_serial_program_verify_port (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
        .HIGH_VOLTAGE_SELECT_PIN(hv), .PROG_SERIAL_CLOCK(sclk), .PROG_SERIAL_DATA_IN(din),
        .PROG_SERIAL_DATA_OUT(dout), .PROG_SERIAL_DATA_OE(oe), .CORE_RESET_N(core_n), .PROG_MODE(mode),
        .ERASE_BUSY(ebusy), .PROGRAM_ACTIVE(pact));
    // Random source, fixed start
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Expected read: protection mask, top bits zero
    function automatic logic [15:0] exp_rd(input logic [10:0] a, input logic [11:0] v, input logic prot);
        return (prot && a >= 11'h040 && a <= 11'h3FE) ? 16'h0000 : {4'h0, v};
    endfunction : exp_rd
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // Upper two code bits random, they must not matter
    task automatic cmd(input logic [3:0] c);
        seed = lfsr(seed);
        i_spv_programmer.cmd({seed[1:0], c});
    endtask : cmd
    task automatic rd(input string what, input logic [15:0] exp);
        cmd(4'h4);
        i_spv_programmer.read();
        check(what, {2'b00, i_spv_programmer.rd_bits[14:1]}, exp);
        check("drive window", i_spv_programmer.oe_bits, 16'h7FFE);
    endtask : rd
    // Load must come first; memory keeps old AND new
    task automatic prog(input logic [13:0] v);
        cmd(4'h2);
        i_spv_programmer.load(v);
        cmd(4'h8);
        check("program active", {15'h0000, pact}, 16'h0001);
        cmd(4'hE);
        check("program ended", {15'h0000, pact}, 16'h0000);
        i_spv_programmer.half();
    endtask : prog
    task automatic erase;
        cmd(4'h9);
        check("erase busy", {15'h0000, ebusy}, 16'h0001);
        wait_n = 0;
        while (ebusy !== 1'b0 && wait_n < 1200)
        begin
            @(negedge CLK_SYS);
            wait_n++;
        end
        check("erase done", {15'h0000, ebusy}, 16'h0000);
    endtask : erase
    // Main sequence
    initial
    begin
        repeat (8) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        RESETN = 1'b1;
        check("core free", {14'h0000, mode, core_n}, 16'h0001);
        i_spv_programmer.enter();
        check("core held", {14'h0000, mode, core_n}, 16'h0002);
        rd("config at entry", 16'h0FFF);
        erase();
        rd("config erased", 16'h0FFF);
        seed = lfsr(seed);
        prog({seed[1:0], 12'hFEF});
        rd("config protected", 16'h0FEF);
        // Every code outside the set is ignored
        for (int c = 0; c < 16; c++)
            if (!(c inside {2, 4, 6, 8, 9, 14}))
                cmd(4'(c));
        rd("after unknown codes", 16'h0FEF);
        $display("test config done");
        cmd(4'h6);
        rd("wrapped erased word", 16'h0FFF);
        seed = lfsr(seed);
        w = seed[11:0];
        prog({seed[13:12], w});
        rd("programmed word", {4'h0, w});
        // Walk user space; edges of the masked range always read
        for (int a = 1; a < 1024; a++)
        begin
            cmd(4'h6);
            seed = lfsr(seed);
            if (a inside {63, 64, 1022, 1023} || seed[5:0] == 6'h00)
                rd("protected space", exp_rd(11'(a), 12'hFFF, 1'b1));
        end
        cmd(4'h6);
        erase();
        rd("user id erased", 16'h0FFF);
        seed = lfsr(seed);
        w = {8'hFF, 1'b0, seed[2:0]};
        prog({2'b00, w});
        rd("user id", {4'h0, w});
        // Trim word sits four above the first ID and went with the full erase
        repeat (4) cmd(4'h6);
        rd("trim erased", 16'h0FFF);
        i_spv_programmer.leave();
        check("mode left", {14'h0000, mode, core_n}, 16'h0001);
        i_spv_programmer.enter();
        rd("config after re-entry", 16'h0FFF);
        $display("test walk done");
        wrap_up();
    end
    // Hang guard, well above the expected run
    initial
    begin
        repeat (95000) @(posedge CLK_SYS);
        bad_count++;
        wrap_up();
    end
endmodule : test_serial_program_verify_port
`default_nettype wire

// ===== design/serial_program_verify_port.sv
// Serial program/verify port with its program and configuration memories
// Behaviour
// - Mode entry holds other logic in reset
// - Entry sets address counter to 0x7FF
// - Space 0x000-0x7FF, user then configuration
// - Increment from 0x3FF goes to 0x400
// - Counter only counts up, 0x7FF wraps
// - Configuration word lost after any increment
// - Six-clock commands, falling edge, LSb first
// - Data segment: start, 14 bits, stop
// - Drive data from 2nd to 15th rise, release at 16th
// - Command codes load, read, increment, program, erase
// - Load keeps 12 of 14 bits
// - Read returns word, top two bits zero
// - Protected program memory reads as zero
// - Configuration memory 0x400-0x43F, IDs 0x400-0x403
// - User IDs read unmasked under protection
// - Trim word survives standard bulk erase
// - Program needs prior load, ends on end
// - Erase clears memory; at 0x400 IDs too
// - Erased program memory reads all ones
// - Protection masks 0x040-0x3FE only
`timescale 1ns/1ps
`default_nettype none
`include "spv_defs.svh"

module serial_program_verify_port
    import spv_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Programmer pins
    input wire logic HIGH_VOLTAGE_SELECT_PIN,
    input wire logic PROG_SERIAL_CLOCK,
    input wire logic PROG_SERIAL_DATA_IN,
    output logic PROG_SERIAL_DATA_OUT,
    output logic PROG_SERIAL_DATA_OE,
    // Device status
    output logic CORE_RESET_N,
    output logic PROG_MODE,
    output logic ERASE_BUSY,
    output logic PROGRAM_ACTIVE
);

    // Two-flop synchronisers plus one history stage for edges
    pin_in_t sync1_r;
    pin_in_t sync2_r;
    pin_in_t hist_r;
    logic clk_rise;
    logic clk_fall;
    logic mode_enter;

    // Control state
    ser_state_t state_r, state_nxt;
    logic [10:0] addr_r, addr_nxt;
    logic cfg_ok_r, cfg_ok_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [5:0] cmd_sr_r, cmd_sr_nxt;
    logic is_read_r, is_read_nxt;
    logic [13:0] io_sr_r, io_sr_nxt;
    logic [11:0] load_word_r, load_word_nxt;
    logic dout_r, dout_nxt;
    logic oe_r, oe_nxt;
    logic prog_act_r, prog_act_nxt;
    logic erasing_r, erasing_nxt;
    logic erase_ids_r, erase_ids_nxt;
    logic [9:0] erase_idx_r, erase_idx_nxt;
    logic [11:0] cfg_word_r, cfg_word_nxt;

    // Memories and their write ports
    logic [11:0] prog_mem [0:`SPV_PROG_WORDS-1];
    logic [11:0] cfg_mem [0:`SPV_CFG_WORDS-1];
    mem_wr_t prog_wr;
    mem_wr_t cfg_wr;

    // Decode helpers
    logic [5:0] cmd_full;
    logic in_user;
    logic in_cfg_mem;
    logic at_cfg_word;
    logic prot_on;
    logic [11:0] rd_word;
    logic [11:0] prog_old;
    logic [11:0] cfg_old;

    // Pin sampling; the first stage feeds only the second
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            hist_r <= '0;
        end
        else
        begin
            sync1_r <= '{clk: PROG_SERIAL_CLOCK, dat: PROG_SERIAL_DATA_IN, hv: HIGH_VOLTAGE_SELECT_PIN};
            sync2_r <= sync1_r;
            hist_r <= sync2_r;
        end
    end

    // Edges of the programmer clock and high voltage pin, seen in the system clock
    assign clk_rise = sync2_r.clk & ~hist_r.clk;
    assign clk_fall = ~sync2_r.clk & hist_r.clk;
    assign mode_enter = sync2_r.hv & ~hist_r.hv;

    // Address decode within the program/verify space
    assign in_user = (addr_r <= `SPV_ADDR_USER_LAST);
    assign in_cfg_mem = (addr_r >= `SPV_ADDR_CFG_BASE) && (addr_r <= `SPV_ADDR_CFG_LAST);
    assign at_cfg_word = (addr_r == `SPV_ADDR_CFG_WORD) && cfg_ok_r;
    assign prot_on = ~cfg_word_r[`SPV_PROT_BIT];
    assign prog_old = prog_mem[addr_r[9:0]];
    assign cfg_old = cfg_mem[addr_r[5:0]];

    // Word seen by a read; IDs and trim bypass the protection mask
    always_comb
    begin
        rd_word = `SPV_WORD_ZERO;
        if (in_user)
        begin
            if (prot_on && (addr_r >= `SPV_ADDR_PROT_LO) && (addr_r <= `SPV_ADDR_PROT_HI))
                rd_word = `SPV_WORD_ZERO;
            else
                rd_word = prog_old;
        end
        else if (in_cfg_mem)
            rd_word = cfg_old;
        else if (at_cfg_word)
            rd_word = cfg_word_r;
    end

    // Newest command bit joins at the top, so bit 0 came first
    assign cmd_full = {sync2_r.dat, cmd_sr_r[5:1]};

    // Next-state logic of the serial engine
    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        cfg_ok_nxt = cfg_ok_r;
        cnt_nxt = cnt_r;
        cmd_sr_nxt = cmd_sr_r;
        is_read_nxt = is_read_r;
        io_sr_nxt = io_sr_r;
        load_word_nxt = load_word_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        prog_act_nxt = prog_act_r;
        erasing_nxt = erasing_r;
        erase_ids_nxt = erase_ids_r;
        erase_idx_nxt = erase_idx_r;
        cfg_word_nxt = cfg_word_r;
        prog_wr = '0;
        cfg_wr = '0;
        // Internally timed erase sweeps one word a cycle
        if (erasing_r)
        begin
            prog_wr = '{we: 1'b1, idx: erase_idx_r, data: `SPV_WORD_ONES};
            if (erase_ids_r && (erase_idx_r <= `SPV_CFG_SWEEP_LAST))
                cfg_wr = '{we: 1'b1, idx: erase_idx_r, data: `SPV_WORD_ONES};
            erase_idx_nxt = erase_idx_r + 10'h001;
            if (erase_idx_r == `SPV_ERASE_LAST)
                erasing_nxt = 1'b0;
        end
        case (state_r)
            ST_IDLE:
            begin
                oe_nxt = 1'b0;
                if (mode_enter)
                begin
                    state_nxt = ST_CMD;
                    addr_nxt = `SPV_ADDR_CFG_WORD;
                    cfg_ok_nxt = 1'b1;
                    cnt_nxt = '0;
                end
            end
            ST_CMD:
            begin
                if (clk_fall)
                begin
                    cmd_sr_nxt = cmd_full;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == `SPV_CMD_BITS)
                    begin
                        cnt_nxt = '0;
                        // Upper two code bits are ignored
                        case (cmd_full[3:0])
                            `SPV_CMD_LOAD:
                            begin
                                state_nxt = ST_DATA;
                                is_read_nxt = 1'b0;
                            end
                            `SPV_CMD_READ:
                            begin
                                state_nxt = ST_DATA;
                                is_read_nxt = 1'b1;
                                io_sr_nxt = {2'b00, rd_word};
                            end
                            `SPV_CMD_INCR:
                            begin
                                cfg_ok_nxt = 1'b0;
                                if (addr_r == `SPV_ADDR_USER_LAST)
                                    addr_nxt = `SPV_ADDR_CFG_BASE;
                                else if (addr_r == `SPV_ADDR_CFG_WORD)
                                    addr_nxt = `SPV_ADDR_ZERO;
                                else
                                    addr_nxt = addr_r + 11'h001;
                            end
                            `SPV_CMD_BEGIN:
                            begin
                                // Program only clears bits; no erase happens
                                prog_act_nxt = 1'b1;
                                if (in_user)
                                    prog_wr = '{we: 1'b1, idx: addr_r[9:0], data: prog_old & load_word_r};
                                else if (in_cfg_mem)
                                    cfg_wr = '{we: 1'b1, idx: {4'h0, addr_r[5:0]}, data: cfg_old & load_word_r};
                                else if (at_cfg_word)
                                    cfg_word_nxt = cfg_word_r & load_word_r;
                            end
                            `SPV_CMD_END:
                                prog_act_nxt = 1'b0;
                            `SPV_CMD_ERASE:
                            begin
                                if (!erasing_r)
                                begin
                                    erasing_nxt = 1'b1;
                                    erase_idx_nxt = '0;
                                    erase_ids_nxt = (addr_r == `SPV_ADDR_CFG_BASE);
                                    cfg_word_nxt = `SPV_WORD_ONES;
                                end
                            end
                            default:
                                state_nxt = ST_CMD;
                        endcase
                    end
                end
            end
            ST_DATA:
            begin
                // Rising edges: start bit, then 14 bits out, then stop
                if (clk_rise)
                begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (is_read_r && (cnt_nxt >= `SPV_DATA_FIRST) && (cnt_nxt <= `SPV_DATA_LAST))
                    begin
                        oe_nxt = 1'b1;
                        dout_nxt = io_sr_r[0];
                        io_sr_nxt = {1'b0, io_sr_r[13:1]};
                    end
                    if (cnt_nxt == `SPV_DATA_STOP)
                        oe_nxt = 1'b0;
                end
                // Falling edges sample load bits; stop bit closes the segment
                if (clk_fall)
                begin
                    if (!is_read_r && (cnt_r >= `SPV_DATA_FIRST) && (cnt_r <= `SPV_DATA_LAST))
                        io_sr_nxt = {sync2_r.dat, io_sr_r[13:1]};
                    if (cnt_r == `SPV_DATA_STOP)
                    begin
                        state_nxt = ST_CMD;
                        cnt_nxt = '0;
                        if (!is_read_r)
                            load_word_nxt = io_sr_r[11:0];
                    end
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // Dropping the high voltage leaves the mode at once
        if (!sync2_r.hv)
        begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            prog_act_nxt = 1'b0;
        end
    end

    // Registers of the serial engine
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_r <= ST_IDLE;
            addr_r <= `SPV_ADDR_CFG_WORD;
            cfg_ok_r <= 1'b0;
            cnt_r <= '0;
            cmd_sr_r <= '0;
            is_read_r <= 1'b0;
            io_sr_r <= '0;
            load_word_r <= `SPV_WORD_ONES;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            prog_act_r <= 1'b0;
            erasing_r <= 1'b0;
            erase_ids_r <= 1'b0;
            erase_idx_r <= '0;
            cfg_word_r <= `SPV_WORD_ONES;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            cfg_ok_r <= cfg_ok_nxt;
            cnt_r <= cnt_nxt;
            cmd_sr_r <= cmd_sr_nxt;
            is_read_r <= is_read_nxt;
            io_sr_r <= io_sr_nxt;
            load_word_r <= load_word_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            prog_act_r <= prog_act_nxt;
            erasing_r <= erasing_nxt;
            erase_ids_r <= erase_ids_nxt;
            erase_idx_r <= erase_idx_nxt;
            cfg_word_r <= cfg_word_nxt;
        end
    end

    // Memory arrays have no reset; contents are nonvolatile
    always_ff @(posedge CLK_SYS)
    begin
        if (prog_wr.we)
            prog_mem[prog_wr.idx] <= prog_wr.data;
        if (cfg_wr.we)
            cfg_mem[cfg_wr.idx[5:0]] <= cfg_wr.data;
    end

    // Outputs
    assign PROG_SERIAL_DATA_OUT = dout_r;
    assign PROG_SERIAL_DATA_OE = oe_r;
    assign CORE_RESET_N = (state_r == ST_IDLE);
    assign PROG_MODE = (state_r != ST_IDLE);
    assign ERASE_BUSY = erasing_r;
    assign PROGRAM_ACTIVE = prog_act_r;

endmodule : serial_program_verify_port
`default_nettype wire

// ===== design/spv_defs.svh
// Constants of the serial program/verify port
`ifndef SPV_DEFS_SVH
`define SPV_DEFS_SVH
// Address map in program/verify mode
`define SPV_ADDR_CFG_WORD 11'h07FF
`define SPV_ADDR_CFG_BASE 11'h0400
`define SPV_ADDR_CFG_LAST 11'h043F
`define SPV_ADDR_USER_LAST 11'h03FF
`define SPV_ADDR_PROT_LO 11'h0040
`define SPV_ADDR_PROT_HI 11'h03FE
`define SPV_ADDR_ZERO 11'h0000
// Command codes, low four bits
`define SPV_CMD_LOAD 4'h2
`define SPV_CMD_READ 4'h4
`define SPV_CMD_INCR 4'h6
`define SPV_CMD_BEGIN 4'h8
`define SPV_CMD_END 4'hE
`define SPV_CMD_ERASE 4'h9
// Frame counter positions in serial clocks
`define SPV_CMD_BITS 5'h05
`define SPV_DATA_FIRST 5'h02
`define SPV_DATA_LAST 5'h0F
`define SPV_DATA_STOP 5'h10
// Field positions and reset values
`define SPV_PROT_BIT 4
`define SPV_WORD_ONES 12'hFFF
`define SPV_WORD_ZERO 12'h000
`define SPV_PROG_WORDS 1024
`define SPV_CFG_WORDS 64
`define SPV_ERASE_LAST 10'h3FF
`define SPV_CFG_SWEEP_LAST 10'h03F
`endif

// ===== design/spv_pkg.sv
// Types of the serial program/verify port
package spv_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_CMD = 3'b010,
        ST_DATA = 3'b100
    } ser_state_t;

    typedef struct packed
    {
        logic we;
        logic [9:0] idx;
        logic [11:0] data;
    } mem_wr_t;

    typedef struct packed
    {
        logic clk;
        logic dat;
        logic hv;
    } pin_in_t;
endpackage : spv_pkg
